// file: hdl/rlsr_regs.sv
// Radio link setup registers with serial command decode and decoded settings
`timescale 1ns/1ps
// Notes on behaviour
// - Width code 01/10/11 selects 3/4/5 address bytes; 00 illegal; reset 11.
// - Below five bytes, only the low bytes of each address are used.
// - Retransmit wait is 250 us times code plus one, end to start.
// - Retry count 0 to 15 after failed acknowledge; 0 disables; reset 0011.
// - Seven-bit channel field, reset 0000010; bit 7 reserved zero.
// - Carrier test tone bit emits unmodulated carrier; reset zero.
// - Rate bits: 00 1 Mbps, 01 2 Mbps, 10 250 kbps; reset 2 Mbps.
// - Low-rate select overrides high-rate select; 11 reserved for software.
// - Bit 4 of radio setup forces synthesizer lock; test only, reset zero.
// - Power code 00..11 gives -18, -12, -6, 0 dBm; reset 11.
// - Registers are reached only through serial read and write commands.
// - Undefined bit positions and unmapped registers read as zero.
module rlsr_regs (
	input  wire logic        MCLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic        SPI_SCK_IN,
	input  wire logic        SPI_CSN_B_IN,
	input  wire logic        SPI_MOSI_IN,
	output logic             SPI_MISO_OUT,
	output logic             SPI_MISO_OE_B_OUT,
	output logic [2:0]       ADDR_WIDTH_BYTES_OUT,
	output logic [4:0]       ADDR_BYTE_MASK_OUT,
	output logic             ADDR_WIDTH_ILLEGAL_OUT,
	output logic [17:0]      RETX_DELAY_CYCLES_OUT,
	output logic [3:0]       RETRY_LIMIT_OUT,
	output logic             RETX_ENABLE_OUT,
	output logic [6:0]       CHANNEL_OUT,
	output logic             CARRIER_TEST_TONE_OUT,
	output logic [1:0]       DATA_RATE_OUT,
	output logic             FORCE_SYNTH_LOCK_OUT,
	output logic [1:0]       TX_POWER_LEVEL_OUT
);

	logic                   cs_active;
	logic                   byte_done;
	logic [7:0]             rx_byte;
	logic                   miso;
	logic                   tx_load_ff;
	logic [7:0]             tx_byte;
	rlsr_pkg::rlsr_state_type state_ff;
	logic [4:0]             cmd_addr_ff;
	logic [2:0]             cmd_op;
	logic                   wr_stb;

	logic [1:0]             addr_width_code_ff;
	logic [3:0]             retransmit_delay_ff;
	logic [3:0]             retry_count_limit_ff;
	logic [6:0]             channel_select_ff;
	logic                   carrier_test_tone_ff;
	logic                   rate_low_select_ff;
	logic                   force_lock_ff;
	logic                   rate_high_select_ff;
	logic [1:0]             tx_power_level_ff;

	logic [2:0]             nxt_width_bytes;
	logic [4:0]             nxt_byte_mask;
	logic [1:0]             nxt_rate;

	rlsr_spi_port u_spi (
		.clk_in        (MCLK_IN),
		.rst_b_in      (RST_B_IN),
		.sck_in        (SPI_SCK_IN),
		.csn_b_in      (SPI_CSN_B_IN),
		.mosi_in       (SPI_MOSI_IN),
		.tx_load_in    (tx_load_ff),
		.tx_byte_in    (tx_byte),
		.cs_active_out (cs_active),
		.byte_done_out (byte_done),
		.rx_byte_out   (rx_byte),
		.miso_out      (miso)
	);

	assign cmd_op = rx_byte[rlsr_pkg::CMD_OP_LSB +: 3];
	assign wr_stb = byte_done && (state_ff == rlsr_pkg::ST_WR);

	// Command sequencer: one command byte, then at most one data byte counts
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_ff    <= rlsr_pkg::ST_IDLE;
			cmd_addr_ff <= 5'h00;
			tx_load_ff  <= 1'b0;
		end else if (!cs_active) begin
			state_ff   <= rlsr_pkg::ST_IDLE;
			tx_load_ff <= 1'b0;
		end else begin
			tx_load_ff <= byte_done && (state_ff == rlsr_pkg::ST_IDLE) &&
				(cmd_op == rlsr_pkg::CMD_READ_OP);
			if (byte_done) begin
				unique case (state_ff)
					rlsr_pkg::ST_IDLE: begin
						cmd_addr_ff <= rx_byte[rlsr_pkg::CMD_ADDR_LSB +: 5];
						if (cmd_op == rlsr_pkg::CMD_READ_OP) begin
							state_ff <= rlsr_pkg::ST_RD;
						end else if (cmd_op == rlsr_pkg::CMD_WRITE_OP) begin
							state_ff <= rlsr_pkg::ST_WR;
						end else begin
							state_ff <= rlsr_pkg::ST_SKIP;
						end
					end
					rlsr_pkg::ST_WR:   state_ff <= rlsr_pkg::ST_SKIP;
					rlsr_pkg::ST_RD:   state_ff <= rlsr_pkg::ST_SKIP;
					rlsr_pkg::ST_SKIP: state_ff <= rlsr_pkg::ST_SKIP;
				endcase
			end
		end
	end

	// Register writes; reserved bits are not stored
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			addr_width_code_ff   <= rlsr_pkg::ADDR_WIDTH_RST;
			retransmit_delay_ff  <= rlsr_pkg::RETX_DELAY_RST;
			retry_count_limit_ff <= rlsr_pkg::RETRY_LIMIT_RST;
			channel_select_ff    <= rlsr_pkg::CHANNEL_RST;
			carrier_test_tone_ff <= rlsr_pkg::CARRIER_TONE_RST;
			rate_low_select_ff   <= rlsr_pkg::RATE_LOW_RST;
			force_lock_ff        <= rlsr_pkg::FORCE_LOCK_RST;
			rate_high_select_ff  <= rlsr_pkg::RATE_HIGH_RST;
			tx_power_level_ff    <= rlsr_pkg::TX_POWER_RST;
		end else if (wr_stb) begin
			unique case (cmd_addr_ff)
				rlsr_pkg::ADDR_WIDTH_CONFIG_OFS: begin
					addr_width_code_ff <= rx_byte[rlsr_pkg::ADDR_WIDTH_LSB +: 2];
				end
				rlsr_pkg::RETRANSMIT_CONFIG_OFS: begin
					retransmit_delay_ff  <= rx_byte[rlsr_pkg::RETX_DELAY_LSB +: 4];
					retry_count_limit_ff <= rx_byte[rlsr_pkg::RETRY_LIMIT_LSB +: 4];
				end
				rlsr_pkg::CHANNEL_SELECT_OFS: begin
					channel_select_ff <= rx_byte[rlsr_pkg::CHANNEL_LSB +: 7];
				end
				rlsr_pkg::RADIO_SETUP_OFS: begin
					carrier_test_tone_ff <= rx_byte[rlsr_pkg::CARRIER_TONE_BIT];
					rate_low_select_ff   <= rx_byte[rlsr_pkg::RATE_LOW_BIT];
					force_lock_ff        <= rx_byte[rlsr_pkg::FORCE_LOCK_BIT];
					rate_high_select_ff  <= rx_byte[rlsr_pkg::RATE_HIGH_BIT];
					tx_power_level_ff    <= rx_byte[rlsr_pkg::TX_POWER_LSB +: 2];
				end
				default: begin
					// Other map entries live outside this bank
				end
			endcase
		end
	end

	// Read-back image; unmapped and reserved bits read zero
	always_comb begin
		tx_byte = 8'h00;
		unique case (cmd_addr_ff)
			rlsr_pkg::ADDR_WIDTH_CONFIG_OFS: begin
				tx_byte[rlsr_pkg::ADDR_WIDTH_LSB +: 2] = addr_width_code_ff;
			end
			rlsr_pkg::RETRANSMIT_CONFIG_OFS: begin
				tx_byte[rlsr_pkg::RETX_DELAY_LSB +: 4]  = retransmit_delay_ff;
				tx_byte[rlsr_pkg::RETRY_LIMIT_LSB +: 4] = retry_count_limit_ff;
			end
			rlsr_pkg::CHANNEL_SELECT_OFS: begin
				tx_byte[rlsr_pkg::CHANNEL_LSB +: 7] = channel_select_ff;
			end
			rlsr_pkg::RADIO_SETUP_OFS: begin
				tx_byte[rlsr_pkg::CARRIER_TONE_BIT]  = carrier_test_tone_ff;
				tx_byte[rlsr_pkg::RATE_LOW_BIT]      = rate_low_select_ff;
				tx_byte[rlsr_pkg::FORCE_LOCK_BIT]    = force_lock_ff;
				tx_byte[rlsr_pkg::RATE_HIGH_BIT]     = rate_high_select_ff;
				tx_byte[rlsr_pkg::TX_POWER_LSB +: 2] = tx_power_level_ff;
			end
			default: begin
				tx_byte = 8'h00;
			end
		endcase
	end

	// Decode of address width into byte count and used-byte mask
	always_comb begin
		unique case (addr_width_code_ff)
			rlsr_pkg::ADDR_WIDTH_3B: begin
				nxt_width_bytes = 3'h3;
				nxt_byte_mask   = 5'h07;
			end
			rlsr_pkg::ADDR_WIDTH_4B: begin
				nxt_width_bytes = 3'h4;
				nxt_byte_mask   = 5'h0f;
			end
			rlsr_pkg::ADDR_WIDTH_5B: begin
				nxt_width_bytes = 3'h5;
				nxt_byte_mask   = 5'h1f;
			end
			rlsr_pkg::ADDR_WIDTH_ILLEGAL: begin
				nxt_width_bytes = 3'h0;
				nxt_byte_mask   = 5'h00;
			end
		endcase
	end

	// Low-rate select wins over high-rate select
	always_comb begin
		if (rate_low_select_ff) begin
			nxt_rate = rlsr_pkg::RATE_250K;
		end else if (rate_high_select_ff) begin
			nxt_rate = rlsr_pkg::RATE_2M;
		end else begin
			nxt_rate = rlsr_pkg::RATE_1M;
		end
	end

	// Settings presented to the radio core
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ADDR_WIDTH_BYTES_OUT   <= 3'h5;
			ADDR_BYTE_MASK_OUT     <= 5'h1f;
			ADDR_WIDTH_ILLEGAL_OUT <= 1'b0;
			RETX_DELAY_CYCLES_OUT  <= rlsr_pkg::RETX_STEP_CYCLES;
			RETRY_LIMIT_OUT        <= rlsr_pkg::RETRY_LIMIT_RST;
			RETX_ENABLE_OUT        <= 1'b1;
			CHANNEL_OUT            <= rlsr_pkg::CHANNEL_RST;
			CARRIER_TEST_TONE_OUT  <= rlsr_pkg::CARRIER_TONE_RST;
			DATA_RATE_OUT          <= rlsr_pkg::RATE_2M;
			FORCE_SYNTH_LOCK_OUT   <= rlsr_pkg::FORCE_LOCK_RST;
			TX_POWER_LEVEL_OUT     <= rlsr_pkg::TX_POWER_RST;
		end else begin
			ADDR_WIDTH_BYTES_OUT   <= nxt_width_bytes;
			ADDR_BYTE_MASK_OUT     <= nxt_byte_mask;
			ADDR_WIDTH_ILLEGAL_OUT <= (addr_width_code_ff == rlsr_pkg::ADDR_WIDTH_ILLEGAL);
			RETX_DELAY_CYCLES_OUT  <= rlsr_pkg::RETX_STEP_CYCLES *
				({14'h0000, retransmit_delay_ff} + 18'h00001);
			RETRY_LIMIT_OUT        <= retry_count_limit_ff;
			RETX_ENABLE_OUT        <= (retry_count_limit_ff != 4'h0);
			CHANNEL_OUT            <= channel_select_ff;
			CARRIER_TEST_TONE_OUT  <= carrier_test_tone_ff;
			DATA_RATE_OUT          <= nxt_rate;
			FORCE_SYNTH_LOCK_OUT   <= force_lock_ff;
			TX_POWER_LEVEL_OUT     <= tx_power_level_ff;
		end
	end

	// Pin driver: enable low while selected
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SPI_MISO_OUT      <= 1'b0;
			SPI_MISO_OE_B_OUT <= 1'b1;
		end else begin
			SPI_MISO_OUT      <= miso;
			SPI_MISO_OE_B_OUT <= ~cs_active;
		end
	end

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_B_IN);

	sequence s_write(logic [4:0] ofs);
		wr_stb && (cmd_addr_ff == ofs);
	endsequence

	sequence s_read_load(logic [4:0] ofs);
		tx_load_ff && (cmd_addr_ff == ofs);
	endsequence

	a_width_four_bytes: assert property (
		s_write(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS) ##0 (rx_byte[1:0] == 2'h2)
			|=> ##1 (ADDR_WIDTH_BYTES_OUT == 3'h4) && !ADDR_WIDTH_ILLEGAL_OUT)
		else $error("address width code 10 did not give four bytes");

	a_mask_tracks_width: assert property (
		(ADDR_WIDTH_BYTES_OUT == 3'h3) |-> (ADDR_BYTE_MASK_OUT == 5'h07))
		else $error("three byte width without low three byte mask");

	a_delay_max_code: assert property (
		s_write(rlsr_pkg::RETRANSMIT_CONFIG_OFS) ##0 (rx_byte[7:4] == 4'hf)
			|=> ##1 (RETX_DELAY_CYCLES_OUT == 18'h30d40))
		else $error("delay code 1111 did not give 4000 us");

	a_retry_disable: assert property (
		RETX_ENABLE_OUT == (RETRY_LIMIT_OUT != 4'h0))
		else $error("retransmit enable disagrees with retry count");

	a_channel_readback: assert property (
		s_read_load(rlsr_pkg::CHANNEL_SELECT_OFS)
			|-> (tx_byte == {1'b0, channel_select_ff}))
		else $error("channel read back wrong or reserved bit set");

	a_carrier_follows: assert property (
		s_write(rlsr_pkg::RADIO_SETUP_OFS) ##0 rx_byte[7] |=> ##1 CARRIER_TEST_TONE_OUT)
		else $error("carrier test tone not raised after write");

	a_rate_low_wins: assert property (
		rate_low_select_ff |=> (DATA_RATE_OUT == rlsr_pkg::RATE_250K))
		else $error("low rate select did not override high rate");

	a_rate_high_only: assert property (
		!rate_low_select_ff && rate_high_select_ff |=> (DATA_RATE_OUT == rlsr_pkg::RATE_2M))
		else $error("high rate select did not give 2 Mbps");

	a_force_lock_bit: assert property (
		s_write(rlsr_pkg::RADIO_SETUP_OFS) ##0 !rx_byte[4] |=> ##1 !FORCE_SYNTH_LOCK_OUT)
		else $error("forced lock set after clearing write");

	a_power_follows: assert property (
		s_write(rlsr_pkg::RADIO_SETUP_OFS)
			|=> ##1 (TX_POWER_LEVEL_OUT == $past(rx_byte[rlsr_pkg::TX_POWER_LSB +: 2], 2)))
		else $error("transmit power does not follow write");

	a_unmapped_zero: assert property (
		tx_load_ff && (cmd_addr_ff > rlsr_pkg::RADIO_SETUP_OFS) |-> (tx_byte == 8'h00))
		else $error("unmapped register read non-zero");

	a_only_by_command: assert property (
		!wr_stb |=> $stable(channel_select_ff) && $stable(tx_power_level_ff))
		else $error("setting changed without write command");

	a_reset_defaults: assert property (
		$rose(RST_B_IN) |-> (addr_width_code_ff == 2'h3) && (retry_count_limit_ff == 4'h3)
			&& (channel_select_ff == 7'h02) && rate_high_select_ff)
		else $error("defaults missing after reset");

endmodule

// file: inc/rlsr_pkg.sv
// Constants and types shared by the radio link setup register bank
package rlsr_pkg;

	// Register offsets within the serial register map
	localparam logic [4:0] ADDR_WIDTH_CONFIG_OFS = 5'h03;
	localparam logic [4:0] RETRANSMIT_CONFIG_OFS = 5'h04;
	localparam logic [4:0] CHANNEL_SELECT_OFS    = 5'h05;
	localparam logic [4:0] RADIO_SETUP_OFS       = 5'h06;

	// Serial command byte layout: opcode in the top three bits
	localparam int         CMD_OP_LSB   = 5;
	localparam int         CMD_ADDR_LSB = 0;
	localparam logic [2:0] CMD_READ_OP  = 3'h0;
	localparam logic [2:0] CMD_WRITE_OP = 3'h1;

	// Field positions
	localparam int ADDR_WIDTH_LSB     = 0;
	localparam int RETX_DELAY_LSB     = 4;
	localparam int RETRY_LIMIT_LSB    = 0;
	localparam int CHANNEL_LSB        = 0;
	localparam int CARRIER_TONE_BIT   = 7;
	localparam int RATE_LOW_BIT       = 5;
	localparam int FORCE_LOCK_BIT     = 4;
	localparam int RATE_HIGH_BIT      = 3;
	localparam int TX_POWER_LSB       = 1;

	// Reset values
	localparam logic [1:0] ADDR_WIDTH_RST   = 2'h3;
	localparam logic [3:0] RETX_DELAY_RST   = 4'h0;
	localparam logic [3:0] RETRY_LIMIT_RST  = 4'h3;
	localparam logic [6:0] CHANNEL_RST      = 7'h02;
	localparam logic       CARRIER_TONE_RST = 1'h0;
	localparam logic       RATE_LOW_RST     = 1'h0;
	localparam logic       FORCE_LOCK_RST   = 1'h0;
	localparam logic       RATE_HIGH_RST    = 1'h1;
	localparam logic [1:0] TX_POWER_RST     = 2'h3;

	// Address width codes and the byte counts they select
	localparam logic [1:0] ADDR_WIDTH_ILLEGAL = 2'h0;
	localparam logic [1:0] ADDR_WIDTH_3B      = 2'h1;
	localparam logic [1:0] ADDR_WIDTH_4B      = 2'h2;
	localparam logic [1:0] ADDR_WIDTH_5B      = 2'h3;

	// Retransmit wait step: one code step at the system clock rate
	localparam int          CLK_FREQ_MHZ     = 50;
	localparam int          RETX_STEP_US     = 250;
	localparam logic [17:0] RETX_STEP_CYCLES = 18'(RETX_STEP_US * CLK_FREQ_MHZ);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WR   = 2'b01,
		ST_RD   = 2'b10,
		ST_SKIP = 2'b11
	} rlsr_state_type;

	typedef enum logic [1:0] {
		RATE_1M   = 2'b00,
		RATE_2M   = 2'b01,
		RATE_250K = 2'b10
	} rlsr_rate_type;

endpackage

// file: hdl/rlsr_spi_port.sv
// Serial peripheral port: pin synchronisers, byte shifter, read-back shifter
`timescale 1ns/1ps
module rlsr_spi_port (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       sck_in,
	input  wire logic       csn_b_in,
	input  wire logic       mosi_in,
	input  wire logic       tx_load_in,
	input  wire logic [7:0] tx_byte_in,
	output logic            cs_active_out,
	output logic            byte_done_out,
	output logic [7:0]      rx_byte_out,
	output logic            miso_out
);

	logic       sck_meta_ff;
	logic       sck_sync_ff;
	logic       sck_prev_ff;
	logic       csn_b_meta_ff;
	logic       csn_b_sync_ff;
	logic       mosi_meta_ff;
	logic       mosi_sync_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] rx_sr_ff;
	logic [7:0] tx_sr_ff;
	logic       byte_done_ff;
	logic       sck_rise;
	logic       sck_fall;

	// Two-stage synchronisers on every pin
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sck_meta_ff   <= 1'b0;
			sck_sync_ff   <= 1'b0;
			sck_prev_ff   <= 1'b0;
			csn_b_meta_ff <= 1'b1;
			csn_b_sync_ff <= 1'b1;
			mosi_meta_ff  <= 1'b0;
			mosi_sync_ff  <= 1'b0;
		end else begin
			sck_meta_ff   <= sck_in;
			sck_sync_ff   <= sck_meta_ff;
			sck_prev_ff   <= sck_sync_ff;
			csn_b_meta_ff <= csn_b_in;
			csn_b_sync_ff <= csn_b_meta_ff;
			mosi_meta_ff  <= mosi_in;
			mosi_sync_ff  <= mosi_meta_ff;
		end
	end

	assign sck_rise      = sck_sync_ff & ~sck_prev_ff;
	assign sck_fall      = ~sck_sync_ff & sck_prev_ff;
	assign cs_active_out = ~csn_b_sync_ff;

	// Sample on rising clock edge, MSB first
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_cnt_ff   <= 3'h0;
			rx_sr_ff     <= 8'h00;
			byte_done_ff <= 1'b0;
		end else if (!cs_active_out) begin
			bit_cnt_ff   <= 3'h0;
			rx_sr_ff     <= 8'h00;
			byte_done_ff <= 1'b0;
		end else begin
			byte_done_ff <= sck_rise && (bit_cnt_ff == 3'h7);
			if (sck_rise) begin
				rx_sr_ff   <= {rx_sr_ff[6:0], mosi_sync_ff};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
			end
		end
	end

	// Shift out on falling edge, except at a byte boundary
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_sr_ff <= 8'h00;
		end else if (!cs_active_out) begin
			tx_sr_ff <= 8'h00;
		end else if (tx_load_in) begin
			tx_sr_ff <= tx_byte_in;
		end else if (sck_fall && (bit_cnt_ff != 3'h0)) begin
			tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
		end
	end

	assign byte_done_out = byte_done_ff;
	assign rx_byte_out   = rx_sr_ff;
	assign miso_out      = tx_sr_ff[7];

endmodule

// file: testbench/rlsr_mcu_model.sv
// Behavioural microcontroller issuing serial register commands
`timescale 1ns/1ps
module rlsr_mcu_model #(
	parameter int HALF_CYC = 6
) (
	input  wire logic clk_in,
	input  wire logic miso_in,
	output logic      sck_out,
	output logic      csn_b_out,
	output logic      mosi_out
);
	initial begin
		sck_out   = 1'b0;
		csn_b_out = 1'b1;
		mosi_out  = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// Mode 0: data set while clock low, both sides sample on the rise
	task automatic shift_byte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			mosi_out = tx[7 - i];
			cyc(HALF_CYC);
			rx      = {rx[6:0], miso_in};
			sck_out = 1'b1;
			cyc(HALF_CYC);
			sck_out = 1'b0;
		end
	endtask

	// Command byte then data byte in one select frame
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input int dbits,
		output logic [7:0] rx);
		logic [7:0] status;
		cyc(1);
		csn_b_out = 1'b0;
		cyc(HALF_CYC);
		shift_byte(cmd, 8, status);
		shift_byte(dat, dbits, rx);
		cyc(HALF_CYC);
		csn_b_out = 1'b1;
		// Released data line must not keep its last value
		mosi_out  = ~mosi_out;
		cyc(2 * HALF_CYC);
	endtask
endmodule

// file: testbench/radio_link_setup_registers_tb_top.sv
// Testbench for the radio link setup register bank
`timescale 1ns/1ps
module radio_link_setup_registers_tb_top;
	logic        mclk_in;
	logic        rst_b_in;
	logic        sck;
	logic        csn_b;
	logic        mosi;
	logic        miso;
	logic        miso_oe_b;
	wire         miso_pin;
	logic [2:0]  aw_bytes;
	logic [4:0]  aw_mask;
	logic        aw_illegal;
	logic [17:0] retx_cyc;
	logic [3:0]  retry;
	logic        retx_en;
	logic [6:0]  chan;
	logic        tone;
	logic [1:0]  rate;
	logic        lock;
	logic [1:0]  pwr;
	logic [7:0]  rd;
	logic [7:0]  val;
	logic [1:0]  kk;
	logic [2:0]  exp_bytes [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
	logic [4:0]  exp_mask  [4] = '{5'h00, 5'h07, 5'h0f, 5'h1f};
	int          error_cnt;
	int          tests_run;

	assign miso_pin = miso_oe_b ? 1'bz : miso;

	rlsr_regs DUT (
		.MCLK_IN               (mclk_in),
		.RST_B_IN              (rst_b_in),
		.SPI_SCK_IN            (sck),
		.SPI_CSN_B_IN          (csn_b),
		.SPI_MOSI_IN           (mosi),
		.SPI_MISO_OUT          (miso),
		.SPI_MISO_OE_B_OUT     (miso_oe_b),
		.ADDR_WIDTH_BYTES_OUT  (aw_bytes),
		.ADDR_BYTE_MASK_OUT    (aw_mask),
		.ADDR_WIDTH_ILLEGAL_OUT(aw_illegal),
		.RETX_DELAY_CYCLES_OUT (retx_cyc),
		.RETRY_LIMIT_OUT       (retry),
		.RETX_ENABLE_OUT       (retx_en),
		.CHANNEL_OUT           (chan),
		.CARRIER_TEST_TONE_OUT (tone),
		.DATA_RATE_OUT         (rate),
		.FORCE_SYNTH_LOCK_OUT  (lock),
		.TX_POWER_LEVEL_OUT    (pwr)
	);

	rlsr_mcu_model u_mcu (
		.clk_in   (mclk_in),
		.miso_in  (miso_pin),
		.sck_out  (sck),
		.csn_b_out(csn_b),
		.mosi_out (mosi)
	);

	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic chk_out(input logic [17:0] exp, input logic [17:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] ofs, input logic [7:0] dat);
		u_mcu.frame({rlsr_pkg::CMD_WRITE_OP, ofs}, dat, 8, rd);
	endtask

	task automatic rd_chk(input logic [4:0] ofs, input logic [7:0] exp);
		u_mcu.frame({rlsr_pkg::CMD_READ_OP, ofs}, 8'h00, 8, rd);
		chk_reg(exp, rd);
	endtask

	task automatic chk_defaults();
		chk_out(18'h5, 18'(aw_bytes));
		chk_out(18'h1f, 18'(aw_mask));
		chk_out(18'h0, 18'(aw_illegal));
		chk_out(rlsr_pkg::RETX_STEP_CYCLES, retx_cyc);
		chk_out(18'h3, 18'(retry));
		chk_out(18'h1, 18'(retx_en));
		chk_out(18'h2, 18'(chan));
		chk_out(18'h0, 18'(tone));
		chk_out(18'h1, 18'(rate));
		chk_out(18'h0, 18'(lock));
		chk_out(18'h3, 18'(pwr));
		chk_out(18'h1, 18'(miso_oe_b));
		chk_out(18'h0, 18'(miso));
		rd_chk(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS, 8'h03);
		rd_chk(rlsr_pkg::RETRANSMIT_CONFIG_OFS, 8'h03);
		rd_chk(rlsr_pkg::CHANNEL_SELECT_OFS, 8'h02);
		rd_chk(rlsr_pkg::RADIO_SETUP_OFS, 8'h0e);
	endtask

	task automatic end_sim();
		$display("errors=%0d comparisons=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		error_cnt = 0;
		tests_run = 0;
		rst_b_in  = 1'b0;
		repeat (16) @(posedge mclk_in);
		#1;
		rst_b_in = 1'b1;
		u_mcu.cyc(4);
		chk_defaults();
		for (int c = 0; c < 4; c++) begin
			wr(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS, 8'(c));
			rd_chk(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS, 8'(c));
			chk_out(18'(exp_bytes[c]), 18'(aw_bytes));
			chk_out(18'(exp_mask[c]), 18'(aw_mask));
			chk_out(18'(c == 0), 18'(aw_illegal));
		end
		wr(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS, 8'hfe);
		rd_chk(rlsr_pkg::ADDR_WIDTH_CONFIG_OFS, 8'h02);
		chk_out(18'h4, 18'(aw_bytes));
		for (int i = 0; i < 16; i++) begin
			val = {4'(i), 4'(15 - i)};
			wr(rlsr_pkg::RETRANSMIT_CONFIG_OFS, val);
			rd_chk(rlsr_pkg::RETRANSMIT_CONFIG_OFS, val);
			chk_out(18'(rlsr_pkg::RETX_STEP_CYCLES * (i + 1)), retx_cyc);
			chk_out(18'(15 - i), 18'(retry));
			chk_out(18'(15 - i != 0), 18'(retx_en));
		end
		wr(rlsr_pkg::CHANNEL_SELECT_OFS, 8'hff);
		rd_chk(rlsr_pkg::CHANNEL_SELECT_OFS, 8'h7f);
		chk_out(18'h7f, 18'(chan));
		wr(rlsr_pkg::CHANNEL_SELECT_OFS, 8'h00);
		chk_out(18'h0, 18'(chan));
		for (int k = 0; k < 4; k++) begin
			kk  = 2'(k);
			val = {kk[0], 1'b1, kk[1], ~kk[0], kk[0], kk, 1'b1};
			wr(rlsr_pkg::RADIO_SETUP_OFS, val);
			rd_chk(rlsr_pkg::RADIO_SETUP_OFS, val & 8'hbe);
			chk_out(18'(kk[0]), 18'(tone));
			chk_out(kk[1] ? 18'h2 : 18'(kk[0]), 18'(rate));
			chk_out(18'(!kk[0]), 18'(lock));
			chk_out(18'(kk), 18'(pwr));
		end
		rd_chk(5'h07, 8'h00);
		wr(5'h07, 8'h55);
		rd_chk(rlsr_pkg::RADIO_SETUP_OFS, 8'hae);
		// Unknown opcode, then a data byte cut short by deselect
		u_mcu.frame({3'h2, rlsr_pkg::CHANNEL_SELECT_OFS}, 8'h33, 8, rd);
		chk_out(18'h0, 18'(chan));
		u_mcu.frame({rlsr_pkg::CMD_WRITE_OP, rlsr_pkg::CHANNEL_SELECT_OFS}, 8'h44, 4, rd);
		chk_out(18'h0, 18'(chan));
		rst_b_in = 1'b0;
		u_mcu.cyc(16);
		rst_b_in = 1'b1;
		u_mcu.cyc(4);
		chk_defaults();
		end_sim();
	end

	initial begin
		#800000;
		error_cnt++;
		end_sim();
	end
endmodule
